// file: logic/dcr_defines.svh
// Offsets, field positions and reset values of the device capability block
`ifndef DCR_DEFINES_SVH
`define DCR_DEFINES_SVH
`define DCR_ADDR_W        8
`define DCR_OFF_DEVCAP    8'hb4
`define DCR_MPS_LSB       0
`define DCR_MPS_MSB       2
`define DCR_MPS_RST       3'h1
`define DCR_MPS_RSVD_MIN  3'h6
`define DCR_PHANTOM_MSB   4
`define DCR_PHANTOM_LSB   3
`define DCR_PHANTOM_VAL   2'h0
`define DCR_XTAG_BIT      5
`define DCR_XTAG_VAL      1'h1
`define DCR_L0S_MSB       8
`define DCR_L0S_LSB       6
`define DCR_L0S_RST       3'h0
`define DCR_L1_MSB        11
`define DCR_L1_LSB        9
`define DCR_L1_RST        3'h0
`define DCR_ABP_BIT       12
`define DCR_AIP_BIT       13
`define DCR_PIP_BIT       14
`define DCR_SPLV_MSB      25
`define DCR_SPLV_LSB      18
`define DCR_SPLV_RST      8'h00
`define DCR_SPLS_MSB      27
`define DCR_SPLS_LSB      26
`define DCR_SPLS_RST      2'h0
`endif

// file: logic/dcr_pkg.sv
// Types shared by the device capability block
package dcr_pkg;
	typedef logic [7:0]  dcr_addr_t;   // Register address
	typedef logic [31:0] dcr_word_t;   // Register data word
	typedef logic [2:0]  dcr_code3_t;  // Three-bit size or latency code
endpackage : dcr_pkg

// file: logic/dcr_devcap.sv
// Device capability register with strap and power limit capture
// What this block does
// [R1] Max payload code in bits 2:0, resets 256B
// [R2] Phantom function field bits 4:3 reads zero
// [R3] Bit 5 reads one: extended tags
// [R4] L0s latency bits 8:6, resets lowest
// [R5] L1 latency bits 11:9, resets lowest
// [R6] Attention button bit follows forward hot-plug strap
// [R7] Indicator bits 13,14 follow forward hot-plug strap
// [R8] Bits 25:18 capture power limit value
// [R9] Bits 27:26 capture power limit scale
//
// Decided for this implementation: the strobed register port.
`include "dcr_defines.svh"
module dcr_devcap #(
	parameter logic [2:0] MPS_CODE = `DCR_MPS_RST,  // Supported payload code
	parameter logic [2:0] L0S_CODE = `DCR_L0S_RST,  // Acceptable L0s code
	parameter logic [2:0] L1_CODE  = `DCR_L1_RST    // Acceptable L1 code
) (
	input  wire logic              CLK_IN,       // Core clock, 10 MHz
	input  wire logic              RST_IN,       // Sync reset, active high
	input  wire dcr_pkg::dcr_addr_t ADDR_IN,     // Register byte address
	input  wire dcr_pkg::dcr_word_t WDATA_IN,    // Write data (ignored)
	input  wire logic              WR_IN,        // Write strobe
	input  wire logic              RD_IN,        // Read strobe
	input  wire logic              HP_STRAP_IN,  // Hot-plug enable strap
	input  wire logic              FWD_MODE_IN,  // High in forward mode
	input  wire logic              SPL_VALID_IN, // Power limit message seen
	input  wire logic [7:0]        SPL_VALUE_IN, // Message limit value
	input  wire logic [1:0]        SPL_SCALE_IN, // Message limit scale
	output logic                   RVALID_OUT,   // Read data valid
	output dcr_pkg::dcr_word_t     RDATA_OUT     // Read data
);
	import dcr_pkg::*;

	dcr_code3_t mps;          // Advertised payload code
	dcr_code3_t l0s;          // Advertised L0s latency code
	dcr_code3_t l1;           // Advertised L1 latency code
	logic       hp_present;   // Hot-plug presence bit
	logic       strap_seen;   // Strap captured once after reset
	logic [7:0] spl_value;    // Captured power limit value
	logic [1:0] spl_scale;    // Captured power limit scale
	dcr_word_t  devcap;       // Assembled register image
	dcr_word_t  next_rdata;   // Read mux result

	// Fixed capability codes; reserved payload codes fall back to reset
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			mps <= `DCR_MPS_RST;  // R1
			l0s <= `DCR_L0S_RST;  // R4
			l1  <= `DCR_L1_RST;   // R5
		end else begin
			// Reserved codes are never advertised
			mps <= (MPS_CODE >= `DCR_MPS_RSVD_MIN) ? `DCR_MPS_RST : MPS_CODE; // R1
			l0s <= L0S_CODE;  // R4
			l1  <= L1_CODE;   // R5
		end
	end

	// Strap is caught by the clock at the first edge after reset release
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			hp_present <= 1'b0;
			strap_seen <= 1'b0;
		end else if (!strap_seen) begin
			hp_present <= HP_STRAP_IN & FWD_MODE_IN;  // R6 R7
			strap_seen <= 1'b1;
		end
	end

	// Capture limit value and scale from each power limit message
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			spl_value <= `DCR_SPLV_RST;  // R8
			spl_scale <= `DCR_SPLS_RST;  // R9
		end else if (SPL_VALID_IN) begin
			spl_value <= SPL_VALUE_IN;   // R8
			spl_scale <= SPL_SCALE_IN;   // R9
		end
	end

	// Register image; reserved bits read zero
	always_comb begin
		devcap = '0;
		devcap[`DCR_MPS_MSB:`DCR_MPS_LSB]         = mps;              // R1
		devcap[`DCR_PHANTOM_MSB:`DCR_PHANTOM_LSB] = `DCR_PHANTOM_VAL; // R2
		devcap[`DCR_XTAG_BIT]                     = `DCR_XTAG_VAL;    // R3
		devcap[`DCR_L0S_MSB:`DCR_L0S_LSB]         = l0s;              // R4
		devcap[`DCR_L1_MSB:`DCR_L1_LSB]           = l1;               // R5
		devcap[`DCR_ABP_BIT]                      = hp_present;       // R6
		devcap[`DCR_AIP_BIT]                      = hp_present;       // R7
		devcap[`DCR_PIP_BIT]                      = hp_present;       // R7
		devcap[`DCR_SPLV_MSB:`DCR_SPLV_LSB]       = spl_value;        // R8
		devcap[`DCR_SPLS_MSB:`DCR_SPLS_LSB]       = spl_scale;        // R9
	end

	// Address decode; unmapped addresses read zero
	always_comb begin
		next_rdata = '0;
		if (RD_IN && ADDR_IN == `DCR_OFF_DEVCAP) begin
			next_rdata = devcap;
		end
	end

	// Read data one cycle after the strobe; writes have no effect
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			RDATA_OUT  <= '0;
			RVALID_OUT <= 1'b0;
		end else begin
			RDATA_OUT  <= next_rdata;
			RVALID_OUT <= RD_IN;
		end
	end

	// A read strobe at the mapped offset asks for the word
	sequence s_map_read;
		RD_IN && ADDR_IN == `DCR_OFF_DEVCAP;
	endsequence

	// Any read strobe, mapped or not
	sequence s_any_read;
		RD_IN;
	endsequence

	// A read strobe at any other address
	sequence s_miss_read;
		RD_IN && ADDR_IN != `DCR_OFF_DEVCAP;
	endsequence

	// Strap still waiting, then captured on the next edge
	sequence s_strap_taken;
		!strap_seen ##1 strap_seen;
	endsequence

	// A power limit message arriving on this edge
	sequence s_limit_msg;
		SPL_VALID_IN;
	endsequence

	// Write strobe after strap capture, no message beside it
	sequence s_quiet_write;
		WR_IN && strap_seen && !SPL_VALID_IN;
	endsequence

	// Payload field never holds a reserved code
	a_mps_legal: assert property ( // R1
		@(posedge CLK_IN) disable iff (RST_IN)
		mps < `DCR_MPS_RSVD_MIN)
		else $error("payload code reserved");

	// Payload code shows its reset value on the release edge
	a_mps_reset: assert property ( // R1
		@(posedge CLK_IN) disable iff (RST_IN)
		$past(RST_IN) |-> mps == `DCR_MPS_RST)
		else $error("payload code reset wrong");

	// A mapped read returns the payload code of the request cycle
	a_mps_read: assert property ( // R1
		@(posedge CLK_IN) disable iff (RST_IN)
		s_map_read |=>
			RDATA_OUT[`DCR_MPS_MSB:`DCR_MPS_LSB] == $past(mps))
		else $error("payload code read wrong");

	// Phantom function field reads zero on every mapped read
	a_phantom_zero: assert property ( // R2
		@(posedge CLK_IN) disable iff (RST_IN)
		s_map_read |=>
			RDATA_OUT[`DCR_PHANTOM_MSB:`DCR_PHANTOM_LSB] == 2'h0)
		else $error("phantom field not zero");

	// Extended tag bit reads one on every mapped read
	a_xtag_one: assert property ( // R3
		@(posedge CLK_IN) disable iff (RST_IN)
		s_map_read |=> RDATA_OUT[`DCR_XTAG_BIT])
		else $error("extended tag bit low");

	// L0s code is the parameter once reset has gone
	a_l0s_code: assert property ( // R4
		@(posedge CLK_IN) disable iff (RST_IN)
		!$past(RST_IN) |-> l0s == L0S_CODE)
		else $error("l0s code wrong");

	// L0s code shows the lowest code on the release edge
	a_l0s_reset: assert property ( // R4
		@(posedge CLK_IN) disable iff (RST_IN)
		$past(RST_IN) |-> l0s == `DCR_L0S_RST)
		else $error("l0s reset code wrong");

	// A mapped read returns the L0s code of the request cycle
	a_l0s_read: assert property ( // R4
		@(posedge CLK_IN) disable iff (RST_IN)
		s_map_read |=>
			RDATA_OUT[`DCR_L0S_MSB:`DCR_L0S_LSB] == $past(l0s))
		else $error("l0s code read wrong");

	// L1 code is the parameter once reset has gone
	a_l1_code: assert property ( // R5
		@(posedge CLK_IN) disable iff (RST_IN)
		!$past(RST_IN) |-> l1 == L1_CODE)
		else $error("l1 code wrong");

	// L1 code shows the lowest code on the release edge
	a_l1_reset: assert property ( // R5
		@(posedge CLK_IN) disable iff (RST_IN)
		$past(RST_IN) |-> l1 == `DCR_L1_RST)
		else $error("l1 reset code wrong");

	// A mapped read returns the L1 code of the request cycle
	a_l1_read: assert property ( // R5
		@(posedge CLK_IN) disable iff (RST_IN)
		s_map_read |=>
			RDATA_OUT[`DCR_L1_MSB:`DCR_L1_LSB] == $past(l1))
		else $error("l1 code read wrong");

	// Presence bit matches the strap sampled on the capture edge
	a_hp_button: assert property ( // R6
		@(posedge CLK_IN) disable iff (RST_IN)
		s_strap_taken |-> hp_present ==
			($past(HP_STRAP_IN) && $past(FWD_MODE_IN)))
		else $error("button bit mismatch");

	// Presence bit is clear on the release edge, before capture
	a_hp_reset: assert property ( // R6
		@(posedge CLK_IN) disable iff (RST_IN)
		$past(RST_IN) |-> !hp_present)
		else $error("presence bit not cleared");

	// Once captured, the presence bit holds until the next reset
	a_hp_hold: assert property ( // R6
		@(posedge CLK_IN) disable iff (RST_IN)
		strap_seen |=> $stable(hp_present))
		else $error("presence bit moved");

	// A mapped read returns the button bit of the request cycle
	a_hp_read: assert property ( // R6
		@(posedge CLK_IN) disable iff (RST_IN)
		s_map_read |=>
			RDATA_OUT[`DCR_ABP_BIT] == $past(hp_present))
		else $error("button bit read wrong");

	// Indicator bits equal the button bit on a read
	a_hp_ind: assert property ( // R7
		@(posedge CLK_IN) disable iff (RST_IN)
		s_map_read |=>
			RDATA_OUT[`DCR_AIP_BIT] == RDATA_OUT[`DCR_ABP_BIT] &&
			RDATA_OUT[`DCR_PIP_BIT] == RDATA_OUT[`DCR_ABP_BIT])
		else $error("indicator bits mismatch");

	// Message value captured one cycle later
	a_spl_value: assert property ( // R8
		@(posedge CLK_IN) disable iff (RST_IN)
		s_limit_msg |=> spl_value == $past(SPL_VALUE_IN))
		else $error("limit value not captured");

	// Value holds between messages
	a_spl_hold: assert property ( // R8
		@(posedge CLK_IN) disable iff (RST_IN)
		!SPL_VALID_IN |=> $stable(spl_value))
		else $error("limit value changed");

	// Value and scale read zero on the release edge
	a_spl_reset: assert property ( // R8 R9
		@(posedge CLK_IN) disable iff (RST_IN)
		$past(RST_IN) |-> spl_value == `DCR_SPLV_RST &&
			spl_scale == `DCR_SPLS_RST)
		else $error("limit reset value wrong");

	// A mapped read returns the value of the request cycle
	a_spl_vread: assert property ( // R8
		@(posedge CLK_IN) disable iff (RST_IN)
		s_map_read |=>
			RDATA_OUT[`DCR_SPLV_MSB:`DCR_SPLV_LSB] == $past(spl_value))
		else $error("limit value read wrong");

	// Message scale held between messages
	a_spl_scale: assert property ( // R9
		@(posedge CLK_IN) disable iff (RST_IN)
		!SPL_VALID_IN && !RST_IN |=> $stable(spl_scale))
		else $error("limit scale changed");

	// Message scale captured one cycle later
	a_scale_capture: assert property ( // R9
		@(posedge CLK_IN) disable iff (RST_IN)
		s_limit_msg |=> spl_scale == $past(SPL_SCALE_IN))
		else $error("limit scale not captured");

	// A mapped read returns the scale of the request cycle
	a_spl_sread: assert property ( // R9
		@(posedge CLK_IN) disable iff (RST_IN)
		s_map_read |=>
			RDATA_OUT[`DCR_SPLS_MSB:`DCR_SPLS_LSB] == $past(spl_scale))
		else $error("limit scale read wrong");

	// Every read strobe is answered in the next cycle
	a_read_valid: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		s_any_read |=> RVALID_OUT)
		else $error("read not answered");

	// Without a strobe both outputs drop to zero
	a_idle_quiet: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		!RD_IN |=> !RVALID_OUT && RDATA_OUT == '0)
		else $error("outputs not idle");

	// Reads of unmapped addresses return zero
	a_miss_zero: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		s_miss_read |=> RDATA_OUT == '0)
		else $error("unmapped read not zero");

	// Reserved bits of the word read zero
	a_rsvd_zero: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		s_map_read |=> RDATA_OUT[31:28] == 4'h0 &&
			RDATA_OUT[17:15] == 3'h0)
		else $error("reserved bits not zero");

	// Writes leave every field alone; the word is read-only
	a_write_ignored: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		s_quiet_write |=> $stable(devcap))
		else $error("write changed the word");

	// Outputs still show their reset values on the release edge
	a_out_reset: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		$past(RST_IN) |-> RDATA_OUT == '0 && !RVALID_OUT)
		else $error("outputs not reset");
endmodule : dcr_devcap

// file: verif/dcr_devcap_tb.sv
// Self-checking bench for the device capability register
module dcr_devcap_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dcr_pkg::*;
	logic       clk;              // Core clock, 100 ns period
	logic       rst;              // Sync reset, active high
	dcr_addr_t  addr;             // Register address
	dcr_word_t  wdata;            // Write data
	logic       wr;               // Write strobe
	logic       rd;               // Read strobe
	logic       hp;               // Hot-plug strap
	logic       fwd;              // Forward mode
	logic       spl_v;            // Power limit message pulse
	logic [7:0] spl_val;          // Message limit value
	logic [1:0] spl_scl;          // Message limit scale
	logic       rvalid;           // Read valid from design
	dcr_word_t  rdata;            // Read data from design
	int         n_mismatch;       // Mismatches seen
	int         samples_checked;  // Comparisons made

	dcr_devcap u_dut (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr),
		.WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .HP_STRAP_IN(hp),
		.FWD_MODE_IN(fwd), .SPL_VALID_IN(spl_v), .SPL_VALUE_IN(spl_val),
		.SPL_SCALE_IN(spl_scl), .RVALID_OUT(rvalid), .RDATA_OUT(rdata));

	// Clock toggles every half period
	always #50 clk = ~clk;

	// Expected register word from strap result and captured limit
	function automatic dcr_word_t exp_word(input logic h, input logic [7:0] v,
		input logic [1:0] s);
		return {4'h0, s, v, 3'h0, {3{h}}, 3'h0, 3'h0, 1'b1, 2'h0, 3'h1};
	endfunction : exp_word

	// Compare one value and count it
	task automatic chk(input string what, input dcr_word_t seen,
		input dcr_word_t exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// One-cycle read, data checked in the following cycle, then idle
	task automatic rd_chk(input dcr_addr_t a, input dcr_word_t exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("read valid", {31'h0, rvalid}, 32'h1);
		chk("read data", rdata, exp);
		@(posedge clk);
		#1;
		chk("idle data", rdata, 32'h0);
		chk("idle valid", {31'h0, rvalid}, 32'h0);
	endtask : rd_chk

	// One-cycle write
	task automatic wr_once(input dcr_addr_t a, input dcr_word_t d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_once

	// Reset for 16 cycles with given straps
	task automatic do_reset(input logic h, input logic f);
		@(posedge clk);
		hp <= h;
		fwd <= f;
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : do_reset

	// One power limit message pulse
	task automatic spl(input logic [7:0] v, input logic [1:0] s);
		@(posedge clk);
		spl_v <= 1'b1;
		spl_val <= v;
		spl_scl <= s;
		@(posedge clk);
		spl_v <= 1'b0;
	endtask : spl

	// Print counts and verdict, then stop
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	// Main test sequence
	initial begin
		{clk, wr, rd, hp, fwd, spl_v, spl_val, spl_scl} = '0;
		{addr, wdata, n_mismatch, samples_checked} = '0;
		rst = 1'b1;
		for (int i = 0; i < 4; i++) begin
			do_reset(i[1], i[0]);
			rd_chk(8'hb4, exp_word(i[1] & i[0], 8'h00, 2'h0));
			$display("strap case %0d done", i);
		end
		wr_once(8'hb4, 32'hffff_ffff);
		rd_chk(8'hb4, exp_word(1'b1, 8'h00, 2'h0));
		rd_chk(8'hb0, 32'h0);
		$display("write and unmapped test done");
		spl(8'hff, 2'h3);
		rd_chk(8'hb4, exp_word(1'b1, 8'hff, 2'h3));
		spl(8'h5a, 2'h1);
		rd_chk(8'hb4, exp_word(1'b1, 8'h5a, 2'h1));
		do_reset(1'b1, 1'b1);
		rd_chk(8'hb4, exp_word(1'b1, 8'h00, 2'h0));
		$display("power limit test done");
		end_sim();
	end

	// Watchdog well beyond the roughly 130 cycles the tests need
	initial begin
		#100000;
		n_mismatch++;
		end_sim();
	end
endmodule : dcr_devcap_tb
